// >>> src/adapter_memory_refresh_bus_glue.sv
// Purpose: Memory decode, CBR refresh and coprocessor glue for the adapter.
// Assumes: Bus requests are synchronous to clk and last one bus cycle minimum.
// Notes:   Refresh pacing and init sequencing are done by CPU firmware/DMA.
`timescale 1ns/1ps
module adapter_memory_refresh_bus_glue
  import glue_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire bus_req_t             req,
  input  wire logic                 large_rom,
  input  wire logic [NUM_BANKS-1:0] bank_fitted,
  input  wire logic                 cpu_hold_req,
  input  wire logic                 coproc_hold_req,
  input  wire logic                 coproc_irq,
  input  wire logic                 coproc_reset_bit,
  input  wire logic                 loopback_bit_n,
  output mem_ctl_t                  mem_ctl,
  output logic                      bus_ready,
  output logic [DATA_W-1:0]         io_rdata,
  output logic                      bus_hold_grant,
  output logic                      attention_strobe,
  output logic                      coproc_irq_input,
  output logic                      coproc_reset,
  output logic                      loopback_en
);

  // Address window checks used by decode and assertions alike
  function automatic logic in_bank(input logic [ADDR_W-1:0] a, input int b);
    return (a <= DRAM_TOP) && (a[ADDR_W-1:BANK_SEL_LSB] == 3'(b));
  endfunction : in_bank

  function automatic logic port_hit(input logic [ADDR_W-1:0] a,
                                    input logic [15:0] port);
    return (a[15:0] & PORT_RANGE_MASK) == port;
  endfunction : port_hit

  logic       refresh_chip_select;
  logic       attn_hit;
  logic       rom_hit;
  logic       io_cyc;
  logic       cbr_cas;
  logic       cbr_ras;
  logic       cbr_busy;
  logic       io_seen_r;
  logic       grant_r;
  logic       attn_r;
  logic       rst_hold_r;
  logic       loop_r;
  logic       irq_r;
  mem_ctl_t   ctl_r;
  logic [3:0] bank_sel;
  logic [2:0] busy_clks_r;

  assign io_cyc              = (req.kind == CYC_IO);
  assign refresh_chip_select = io_cyc && port_hit(req.addr, REFRESH_PORT);
  assign attn_hit            = io_cyc && port_hit(req.addr, ATTN_PORT);

  // ROM window depends on fitted ROM size; either master may reach it
  assign rom_hit = (req.kind == CYC_MEM_RD || req.kind == CYC_MEM_WR) &&
                   (large_rom ? (req.addr >= ROM_LARGE_BASE)
                              : (req.addr >= ROM_SMALL_BASE));

  // Contiguous bank decode, gated by which banks are fitted
  always_comb begin
    bank_sel = 4'h0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      bank_sel[b] = (req.kind == CYC_MEM_RD || req.kind == CYC_MEM_WR) &&
                    in_bank(req.addr, b) && bank_fitted[b];
    end
  end

  // One launch per I/O cycle, even if the cycle lasts several clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) io_seen_r <= 1'b0;
    else         io_seen_r <= io_cyc;
  end

  cbr_sequencer u_cbr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (refresh_chip_select && !io_seen_r),
    .cas_act (cbr_cas),
    .ras_act (cbr_ras),
    .busy    (cbr_busy)
  );

  // Array strobes registered; CBR drives every fitted bank, never write enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_r <= '{ras_n: 4'hf, cas_n: 4'hf, we_n: 1'b1, rom_cs_n: 1'b1};
    end else if (cbr_busy) begin
      ctl_r.ras_n    <= cbr_ras ? ~bank_fitted : 4'hf;
      ctl_r.cas_n    <= cbr_cas ? ~bank_fitted : 4'hf;
      ctl_r.we_n     <= 1'b1;
      ctl_r.rom_cs_n <= 1'b1;
    end else begin
      ctl_r.ras_n    <= ~bank_sel;
      ctl_r.cas_n    <= ~bank_sel;
      ctl_r.we_n     <= ~(req.kind == CYC_MEM_WR && |bank_sel);
      ctl_r.rom_cs_n <= ~rom_hit;
    end
  end
  assign mem_ctl = ctl_r;

  // Clocks spent in the running refresh; one refresh must fit one bus cycle
  // so a read-then-write refresh transfer never stalls the bus owner
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)       busy_clks_r <= 3'h0;
    else if (cbr_busy) busy_clks_r <= busy_clks_r + 3'h1;
    else               busy_clks_r <= 3'h0;
  end

  // Port cycles finish with no wait states; memory waits out a refresh
  assign bus_ready = io_cyc || !cbr_busy;
  assign io_rdata  = '0;

  // Single bus owner: coprocessor gets grant only while CPU yields
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)                          grant_r <= 1'b0;
    else if (!coproc_hold_req)            grant_r <= 1'b0;
    else if (!cpu_hold_req && !cbr_busy)  grant_r <= 1'b1;
  end
  assign bus_hold_grant = grant_r;

  // Channel attention pulse on the first clock of an attention access
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) attn_r <= 1'b0;
    else         attn_r <= attn_hit && !io_seen_r;
  end
  assign attention_strobe = attn_r;

  // Reset hold and loopback follow control bits; registered for clean edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_hold_r <= 1'b1;
      loop_r     <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      rst_hold_r <= coproc_reset_bit;
      loop_r     <= !loopback_bit_n;
      irq_r      <= coproc_irq;
    end
  end
  assign coproc_reset     = rst_hold_r;
  assign loopback_en      = loop_r;
  assign coproc_irq_input = irq_r;

  // Assertions
  refresh_launch_a: assert property (@(posedge clk) disable iff (sys_rst)
    (refresh_chip_select && !io_seen_r && !cbr_busy) |-> ##2 (ctl_r.cas_n == ~bank_fitted))
    else $error("Refresh did not strobe all banks");
  refresh_no_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(cbr_busy) |-> ctl_r.we_n)
    else $error("Write enable during refresh");
  bank_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.kind == CYC_MEM_RD && req.addr == 20'h20000 && bank_fitted[1] && !cbr_busy)
      |=> (ctl_r.ras_n == 4'hd))
    else $error("Bank decode wrong");
  rom_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.kind == CYC_MEM_RD && !cbr_busy && !large_rom && req.addr < ROM_SMALL_BASE)
      |=> ctl_r.rom_cs_n)
    else $error("ROM decode outside window");
  bus_owner_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_hold_req && !bus_hold_grant) |=> !bus_hold_grant)
    else $error("Grant while CPU owns bus");
  attn_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    (attn_hit && !io_seen_r) |=> attention_strobe ##1 !attention_strobe)
    else $error("Attention pulse wrong");
  irq_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (coproc_irq_input == $past(coproc_irq)))
    else $error("Interrupt not passed through");
  reset_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    coproc_reset_bit [*2] |-> coproc_reset)
    else $error("Coprocessor not held in reset");
  loopback_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(loopback_bit_n) |=> loopback_en)
    else $error("Loopback polarity wrong");
  no_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    io_cyc |-> bus_ready)
    else $error("Wait state on port access");

  // Refresh walk on the array strobes: CAS alone, then both, then released
  sequence cas_only_s;
    (ctl_r.cas_n == ~bank_fitted) && (ctl_r.ras_n == 4'hf);
  endsequence
  sequence both_low_s;
    ((ctl_r.cas_n == ~bank_fitted) && (ctl_r.ras_n == ~bank_fitted)) [*2];
  endsequence
  sequence released_s;
    (ctl_r.cas_n == 4'hf) && (ctl_r.ras_n == 4'hf);
  endsequence
  refresh_walk_a: assert property (@(posedge clk) disable iff (sys_rst)
    (refresh_chip_select && !io_seen_r && !cbr_busy)
      |-> ##2 cas_only_s ##1 both_low_s ##1 released_s)
    else $error("Refresh strobe walk wrong");

  // Write decode, large ROM window and grant hold-off during refresh
  grant_refresh_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cbr_busy && !bus_hold_grant) |=> !bus_hold_grant)
    else $error("Grant given during refresh");
  write_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.kind == CYC_MEM_WR && |bank_sel && !cbr_busy)
      |=> !ctl_r.we_n)
    else $error("Write enable missing on bank write");
  rom_large_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.kind == CYC_MEM_RD && !cbr_busy && large_rom && req.addr >= ROM_LARGE_BASE)
      |=> !ctl_r.rom_cs_n)
    else $error("Large ROM window not decoded");

  // A held or repeated port cycle must not pulse attention twice
  attn_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    io_seen_r |=> !attention_strobe)
    else $error("Attention pulse repeated");
  reset_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!coproc_reset_bit) [*2] |-> !coproc_reset)
    else $error("Coprocessor reset not released");
  loopback_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(loopback_bit_n) |=> !loopback_en)
    else $error("Loopback not released");

  // A refresh longer than one bus cycle would overrun the next transfer
  cbr_fits_a: assert property (@(posedge clk) disable iff (sys_rst)
    busy_clks_r <= 3'(BUS_CYCLE_CLKS))
    else $error("Refresh longer than a bus cycle");

endmodule : adapter_memory_refresh_bus_glue

// >>> src/cbr_sequencer.sv
// Purpose: CAS-before-RAS refresh cycle generator for every fitted bank at once.
// Assumes: start is a one-cycle pulse; a pulse while busy is absorbed.
// Notes:   Write enable is never touched here.
`timescale 1ns/1ps
module cbr_sequencer
  import glue_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      cas_act,
  output logic      ras_act,
  output logic      busy
);
  typedef enum logic [1:0] {S_IDLE, S_CAS, S_RAS, S_PRE} cbr_st_t;
  cbr_st_t    st_r;
  logic [2:0] cnt_r;

  // Sequence CAS first, then RAS, then precharge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r  <= S_IDLE;
      cnt_r <= 3'h0;
    end else begin
      case (st_r)
        S_IDLE: if (start) begin
          st_r  <= S_CAS;
          cnt_r <= CBR_CAS_CLKS - 3'h1;
        end
        S_CAS: if (cnt_r == 3'h0) begin
          st_r  <= S_RAS;
          cnt_r <= CBR_RAS_CLKS - 3'h1;
        end else cnt_r <= cnt_r - 3'h1;
        S_RAS: if (cnt_r == 3'h0) begin
          st_r  <= S_PRE;
          cnt_r <= CBR_PRE_CLKS - 3'h1;
        end else cnt_r <= cnt_r - 3'h1;
        S_PRE: if (cnt_r == 3'h0) st_r <= S_IDLE;
          else cnt_r <= cnt_r - 3'h1;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  assign cas_act = (st_r == S_CAS) || (st_r == S_RAS);
  assign ras_act = (st_r == S_RAS);
  assign busy    = (st_r != S_IDLE);

  // CAS must lead RAS by the set lead time
  sequence cas_lead_s;
    (st_r == S_IDLE && start) ##1 (cas_act && !ras_act);
  endsequence
  cbr_order_a: assert property (@(posedge clk) disable iff (sys_rst)
    cas_lead_s |=> ras_act [*2] ##1 (!ras_act && !cas_act))
    else $error("CBR order wrong");
endmodule : cbr_sequencer

// >>> src/glue_pkg.sv
// Purpose: Constants and carrier types for the adapter memory and bus glue.
// Assumes: 8 MHz local bus clock, 20-bit byte addresses, 16-bit I/O ports.
// Notes:   All offsets, windows and timing counts live here.
package glue_pkg;

  localparam int          ADDR_W          = 20;
  localparam int          DATA_W          = 16;
  localparam int          NUM_BANKS       = 4;
  localparam int          BANK_SEL_LSB    = 17;
  localparam logic [19:0] DRAM_TOP        = 20'h7ffff;
  localparam logic [19:0] ROM_SMALL_BASE  = 20'hfc000;
  localparam logic [19:0] ROM_LARGE_BASE  = 20'he0000;
  localparam logic [15:0] REFRESH_PORT    = 16'h0080;
  localparam logic [15:0] ATTN_PORT       = 16'h0000;
  localparam logic [15:0] PORT_RANGE_MASK = 16'hfffe;
  // Clock and bus cycle timing
  localparam int          CLK_MHZ         = 8;
  localparam int          BUS_CYCLE_NS    = 500;
  localparam int          CLK_PERIOD_NS   = 1000 / CLK_MHZ;
  localparam int          BUS_CYCLE_CLKS  = BUS_CYCLE_NS / CLK_PERIOD_NS;
  // CBR sequence lengths in clocks: CAS lead, RAS hold, precharge
  localparam logic [2:0]  CBR_CAS_CLKS    = 3'h1;
  localparam logic [2:0]  CBR_RAS_CLKS    = 3'h2;
  localparam logic [2:0]  CBR_PRE_CLKS    = 3'h1;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_MEM_RD,
    CYC_MEM_WR,
    CYC_IO
  } cyc_kind_t;

  // One bus request from whichever master owns the bus
  typedef struct packed {
    cyc_kind_t         kind;
    logic              io_wr;
    logic [ADDR_W-1:0] addr;
  } bus_req_t;

  // DRAM and ROM strobes, active low on the array
  typedef struct packed {
    logic [NUM_BANKS-1:0] ras_n;
    logic [NUM_BANKS-1:0] cas_n;
    logic                 we_n;
    logic                 rom_cs_n;
  } mem_ctl_t;

endpackage : glue_pkg

// >>> verif/adapter_memory_refresh_bus_glue_tb.sv
// Purpose: Self-checking bench for decode, refresh and coprocessor glue.
// Assumes: Strobe vectors are compared on their first cycle away from idle.
// Notes:   Driver calls with n set note the expected event; a monitor pops and compares.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adapter_memory_refresh_bus_glue_tb;
  import glue_pkg::*;
  localparam int        INIT_WAIT = 20000; // Power-up settle at 10 ns per clock
  logic                 clk, sys_rst, large_rom, cpu_hold_req, coproc_hold_req;
  logic                 coproc_irq, coproc_reset_bit, loopback_bit_n, bus_ready, rdy;
  logic                 bus_hold_grant, attention_strobe, coproc_irq_input;
  logic                 coproc_reset, loopback_en;
  logic [NUM_BANKS-1:0] bank_fitted, bf;
  logic [DATA_W-1:0]    io_rdata;
  logic [10:0]          notes[$], vec, prev, exp_v;
  logic [19:0]          a;
  bus_req_t             req;
  mem_ctl_t             mem_ctl;
  int                   num_errors = 0, checks = 0;

  bus_masters_model bus_masters_model_i (.clk(clk), .bus_ready(bus_ready), .req(req));
  adapter_memory_refresh_bus_glue adapter_memory_refresh_bus_glue_i (
    .clk(clk), .sys_rst(sys_rst), .req(req), .large_rom(large_rom),
    .bank_fitted(bank_fitted), .cpu_hold_req(cpu_hold_req),
    .coproc_hold_req(coproc_hold_req), .coproc_irq(coproc_irq),
    .coproc_reset_bit(coproc_reset_bit), .loopback_bit_n(loopback_bit_n),
    .mem_ctl(mem_ctl), .bus_ready(bus_ready), .io_rdata(io_rdata),
    .bus_hold_grant(bus_hold_grant), .attention_strobe(attention_strobe),
    .coproc_irq_input(coproc_irq_input), .coproc_reset(coproc_reset),
    .loopback_en(loopback_en));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Idle is all strobes high and no attention pulse
  assign vec = {mem_ctl.ras_n, mem_ctl.cas_n, mem_ctl.we_n, mem_ctl.rom_cs_n, attention_strobe};

  // Monitor: each new event away from idle must match the oldest note
  always @(negedge clk) begin
    if (!sys_rst && vec != 11'h7fe && prev == 11'h7fe) begin
      exp_v = (notes.size() == 0) ? 11'h7fe : notes.pop_front();
      `CHK("bus event", exp_v, vec)
    end
    prev = vec;
  end

  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // One access with its expected event, then enough idle for a refresh to finish
  task automatic acc(input cyc_kind_t k, input logic [19:0] ad, input logic [10:0] e,
                     input bit n);
    if (n) notes.push_back(e);
    bus_masters_model_i.cycle(k, 1'($urandom_range(0, 1)), ad, rdy);
    if (k == CYC_IO) begin
      `CHK("io ready", 1'b1, rdy)
      `CHK("io rdata", 16'h0, io_rdata)
    end
    repeat (6) @(posedge clk);
  endtask : acc

  // Watchdog sized well past the power-up wait plus all traffic
  initial begin
    #400000;
    num_errors++;
    results();
  end

  initial begin
    void'($urandom(15));
    {sys_rst, large_rom, cpu_hold_req, coproc_hold_req, coproc_irq} = 5'h10;
    {coproc_reset_bit, loopback_bit_n, bank_fitted} = 6'h1f;
    repeat (15) @(posedge clk);
    `CHK("reset hold", 1'b1, coproc_reset)
    `CHK("reset grant", 1'b0, bus_hold_grant)
    @(posedge clk);
    sys_rst <= 1'b0;
    // Control bits in every combination, service request following the loopback bit
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {coproc_reset_bit, loopback_bit_n, coproc_irq} <= {i[1:0], i[0]};
      repeat (3) @(posedge clk);
      `CHK("coproc reset", i[1], coproc_reset)
      `CHK("loopback", ~i[0], loopback_en)
      `CHK("irq route", i[0], coproc_irq_input)
    end
    coproc_hold_req <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("grant on", 1'b1, bus_hold_grant)
    coproc_hold_req <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("grant off", 1'b0, bus_hold_grant)
    cpu_hold_req    <= 1'b1;
    coproc_hold_req <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("grant held off", 1'b0, bus_hold_grant)
    cpu_hold_req    <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("grant after cpu", 1'b1, bus_hold_grant)
    coproc_hold_req <= 1'b0;
    repeat (INIT_WAIT) @(posedge clk);
    // Eight init refreshes with random fitted banks and ignored upper port bits
    for (int i = 0; i < 8; i++) begin
      bf = 4'($urandom_range(1, 15));
      bank_fitted <= bf;
      acc(CYC_IO, {4'($urandom), 15'h0040, 1'($urandom)}, {4'hf, ~bf, 3'h6}, 1);
    end
    // A refresh during a running one is dropped
    notes.push_back({4'hf, ~bf, 3'h6});
    bus_masters_model_i.cycle(CYC_IO, 1'b0, 20'h00080, rdy);
    acc(CYC_IO, 20'h00080, 11'h0, 0);
    // Timer-paced DMA: one read then one write per trigger, no bursts
    for (int i = 0; i < 3; i++) begin
      notes.push_back({4'hf, ~bf, 3'h6});
      bus_masters_model_i.cycle(CYC_IO, 1'b0, 20'h00080, rdy);
      repeat (6) @(posedge clk);
      notes.push_back({4'hf, ~bf, 3'h6});
      bus_masters_model_i.cycle(CYC_IO, 1'b1, 20'h00080, rdy);
      repeat (30) @(posedge clk);
    end
    acc(CYC_IO, 20'h00000, 11'h7ff, 1);
    acc(CYC_IO, 20'h00001, 11'h7ff, 1);
    bank_fitted <= 4'hf;
    // Eight accesses per bank, reads and writes alternating
    for (int k = 0; k < 32; k++) begin
      bf = ~(4'h1 << k[4:3]);
      a  = {1'b0, k[4:3], 17'($urandom)};
      acc(k[0] ? CYC_MEM_WR : CYC_MEM_RD, a, {bf, bf, ~k[0], 2'h2}, 1);
    end
    acc(CYC_MEM_RD, 20'hfc000 | 20'($urandom_range(0, 16383)), 11'h7fc, 1);
    acc(CYC_MEM_RD, 20'he0000, 11'h0, 0);
    acc(CYC_MEM_RD, 20'h90000, 11'h0, 0);
    large_rom <= 1'b1;
    acc(CYC_MEM_RD, 20'he0000 | 20'($urandom), 11'h7fc, 1);
    `CHK("notes left", 0, notes.size())
    results();
  end
endmodule : adapter_memory_refresh_bus_glue_tb

// >>> verif/bus_masters_model.sv
// Purpose: Shared-bus master stand-in: CPU firmware and DMA issuing bus cycles.
// Assumes: One owner at a time; each cycle holds for exactly one clock.
// Notes:   Released address lines show the inverse of the last value, never stale.
`timescale 1ns/1ps
module bus_masters_model
  import glue_pkg::*;
(
  input  wire logic clk,
  input  wire logic bus_ready,
  output bus_req_t  req
);
  initial req = '{kind: CYC_IDLE, io_wr: 1'b0, addr: '0};

  // One bus cycle, ready taken at the closing edge, then the bus is released
  task automatic cycle(input cyc_kind_t k, input logic wr, input logic [ADDR_W-1:0] a,
                       output logic rdy);
    @(posedge clk);
    req <= '{kind: k, io_wr: wr, addr: a};
    @(posedge clk);
    rdy = bus_ready;
    req <= '{kind: CYC_IDLE, io_wr: ~wr, addr: ~a};
  endtask : cycle
endmodule : bus_masters_model
